/* File: logic/can_vector_and_fifo_config.sv */
// Vector status and DMA buffer configuration registers behind AXI4-Lite.
// Overview of operation
// - Report accepting filter 0 to 15, five bits.
// - Codes 1000100 almost-full, 1000011 receive overflow.
// - Buffer interrupts use the buffer number code.
// - Three-bit selection sizes DMA buffer area.
// - Five-bit field names first FIFO buffer.
// - Unimplemented bits read zero, writes ignored.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module can_vector_and_fifo_config (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [can_vec_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [can_vec_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic filter_hit_i,
	input wire logic [can_vec_pkg::MFI_W-1:0] filter_index_i,
	input wire logic buf_irq_i,
	input wire logic [can_vec_pkg::CODE_W-1:0] buf_irq_num_i,
	input wire logic rx_overflow_i,
	input wire logic fifo_almost_full_i,
	output logic [can_vec_pkg::BCS_W-1:0] dma_buffer_count_sel_o,
	output logic [5:0] dma_buffer_count_o,
	output logic [can_vec_pkg::FIRST_W-1:0] fifo_area_first_buffer_o,
	output logic irq_o
);
	import can_vec_pkg::*;

	typedef struct packed {
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [MFI_W-1:0] matched_filter_index;
		logic buf_pending;
		logic [CODE_W-1:0] buf_code;
		logic ovf_pending;
		logic full_pending;
		logic [BCS_W-1:0] dma_buffer_count_sel;
		logic [FIRST_W-1:0] fifo_area_first_buffer;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_enable;
		logic [5:0] buf_count;
	} state_s;

	typedef enum logic [2:0] {
		REG_VECTOR,
		REG_FIFO_CTRL,
		REG_IRQ_STATUS,
		REG_IRQ_CLEAR,
		REG_IRQ_ENABLE,
		REG_BUF_LIMITS,
		REG_NONE
	} reg_id_e;

	state_s state_r;
	state_s state_nxt;
	logic [5:0] dec_count;
	logic dec_reserved;
	logic [CODE_W-1:0] pending_irq_code;
	logic [15:0] vector_word;
	logic [15:0] fifo_ctrl_word;
	logic wr_go;
	logic rd_go;
	// Decoded register of the pending write and of the offered read.
	reg_id_e wr_reg;
	reg_id_e rd_reg;
	logic aw_take;
	logic w_take;
	logic b_done;
	logic r_done;
	logic filter_take;
	logic buf_take;
	logic [31:0] ctrl_merged;
	logic [31:0] enable_merged;
	logic [31:0] limits_word;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] status_nxt;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	function automatic logic addr_known(input logic [ADDR_W-1:0] a);
		logic ok;
		ok = 1'b0;
		if (a == OFS_VECTOR) begin
			ok = 1'b1;
		end else if (a == OFS_FIFO_CTRL) begin
			ok = 1'b1;
		end else if (a == OFS_IRQ_STATUS) begin
			ok = 1'b1;
		end else if (a == OFS_IRQ_CLEAR) begin
			ok = 1'b1;
		end else if (a == OFS_IRQ_ENABLE) begin
			ok = 1'b1;
		end else if (a == OFS_BUF_LIMITS) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : addr_known

	// One decoder serves both paths so reads and writes agree on the map.
	function automatic reg_id_e decode_reg(input logic [ADDR_W-1:0] a);
		reg_id_e id;
		id = REG_NONE;
		if (a == OFS_VECTOR) begin
			id = REG_VECTOR;
		end else if (a == OFS_FIFO_CTRL) begin
			id = REG_FIFO_CTRL;
		end else if (a == OFS_IRQ_STATUS) begin
			id = REG_IRQ_STATUS;
		end else if (a == OFS_IRQ_CLEAR) begin
			id = REG_IRQ_CLEAR;
		end else if (a == OFS_IRQ_ENABLE) begin
			id = REG_IRQ_ENABLE;
		end else if (a == OFS_BUF_LIMITS) begin
			id = REG_BUF_LIMITS;
		end
		return id;
	endfunction : decode_reg

	can_buf_count_dec u_dec (
		.sel_i(state_r.dma_buffer_count_sel),
		.count_o(dec_count),
		.reserved_o(dec_reserved)
	);

	can_code_mux u_mux (
		.ovf_i(state_r.ovf_pending),
		.full_i(state_r.full_pending),
		.buf_valid_i(state_r.buf_pending),
		.buf_code_i(state_r.buf_code),
		.code_o(pending_irq_code)
	);

	// Unimplemented positions are built as constant zero, never stored.
	always_comb begin
		vector_word = 16'h0000;
		vector_word[MFI_LSB +: MFI_W] = state_r.matched_filter_index;
		vector_word[CODE_W-1:0] = pending_irq_code;
		fifo_ctrl_word = 16'h0000;
		fifo_ctrl_word[BCS_LSB +: BCS_W] = state_r.dma_buffer_count_sel;
		fifo_ctrl_word[FIRST_W-1:0] = state_r.fifo_area_first_buffer;
		limits_word = {19'h0, state_r.fifo_area_first_buffer, 2'h0,
			state_r.buf_count};
	end

	assign s_axi_awready = !state_r.aw_held && !state_r.bvalid;
	assign s_axi_wready = !state_r.w_held && !state_r.bvalid;
	assign s_axi_arready = !state_r.rvalid;
	assign s_axi_bvalid = state_r.bvalid;
	assign s_axi_bresp = state_r.bresp;
	assign s_axi_rvalid = state_r.rvalid;
	assign s_axi_rdata = state_r.rdata;
	assign s_axi_rresp = state_r.rresp;
	assign dma_buffer_count_sel_o = state_r.dma_buffer_count_sel;
	assign dma_buffer_count_o = state_r.buf_count;
	assign fifo_area_first_buffer_o = state_r.fifo_area_first_buffer;
	assign irq_o = |(state_r.irq_status & state_r.irq_enable);
	assign wr_go = state_r.aw_held && state_r.w_held && !state_r.bvalid;
	assign rd_go = s_axi_arvalid && !state_r.rvalid;
	// Handshake strobes, named once so each path reads the same term.
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign b_done = state_r.bvalid && s_axi_bready;
	assign r_done = state_r.rvalid && s_axi_rready;
	assign filter_take = filter_hit_i && filter_index_i <= FILTER_MAX;
	assign buf_take = buf_irq_i && buf_irq_num_i <= CODE_BUF_MAX;
	assign wr_reg = decode_reg(state_r.aw_addr);
	assign rd_reg = decode_reg(s_axi_araddr);
	assign ctrl_merged = merge_bytes({16'h0000, fifo_ctrl_word},
		state_r.w_data, state_r.w_strb);
	assign enable_merged = merge_bytes({28'h0, state_r.irq_enable},
		state_r.w_data, state_r.w_strb);

	// The clear register acts only on its low byte lane.
	always_comb begin
		irq_clr = '0;
		if (wr_go && wr_reg == REG_IRQ_CLEAR && state_r.w_strb[0]) begin
			irq_clr = state_r.w_data[IRQ_W-1:0];
		end
	end

	always_comb begin
		irq_events = '0;
		irq_events[IRQ_BUF] = buf_take;
		irq_events[IRQ_OVF] = rx_overflow_i;
		irq_events[IRQ_FULL] = fifo_almost_full_i;
		irq_events[IRQ_BADCFG] = dec_reserved;
	end

	// Set beats clear so an event in the clearing cycle survives.
	for (genvar g = 0; g < IRQ_W; g++) begin : g_status
		assign status_nxt[g] = irq_events[g]
			|| (state_r.irq_status[g] && !irq_clr[g]);
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		if (rd_reg == REG_VECTOR) begin
			rd_word = {16'h0000, vector_word};
		end else if (rd_reg == REG_FIFO_CTRL) begin
			rd_word = {16'h0000, fifo_ctrl_word};
		end else if (rd_reg == REG_IRQ_STATUS) begin
			rd_word = {28'h0, state_r.irq_status};
		end else if (rd_reg == REG_IRQ_ENABLE) begin
			rd_word = {28'h0, state_r.irq_enable};
		end else if (rd_reg == REG_BUF_LIMITS) begin
			rd_word = limits_word;
		end
	end

	always_comb begin
		state_nxt = state_r;
		state_nxt.buf_count = dec_count;
		state_nxt.irq_status = status_nxt;

		if (aw_take) begin
			state_nxt.aw_held = 1'b1;
			state_nxt.aw_addr = s_axi_awaddr;
		end
		if (w_take) begin
			state_nxt.w_held = 1'b1;
			state_nxt.w_data = s_axi_wdata;
			state_nxt.w_strb = s_axi_wstrb;
		end
		if (b_done) begin
			state_nxt.bvalid = 1'b0;
		end
		if (r_done) begin
			state_nxt.rvalid = 1'b0;
		end

		// Filter index above fifteen is reserved and is not latched.
		if (filter_take) begin
			state_nxt.matched_filter_index = filter_index_i;
		end

		if (wr_go) begin
			state_nxt.aw_held = 1'b0;
			state_nxt.w_held = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = addr_known(state_r.aw_addr) ? RESP_OKAY
				: RESP_SLVERR;
			if (wr_reg == REG_FIFO_CTRL) begin
				state_nxt.dma_buffer_count_sel =
					ctrl_merged[BCS_LSB +: BCS_W];
				state_nxt.fifo_area_first_buffer =
					ctrl_merged[FIRST_W-1:0];
			end else if (wr_reg == REG_IRQ_ENABLE) begin
				state_nxt.irq_enable = enable_merged[IRQ_W-1:0];
			end
		end

		// Pending sources are cleared by the status-clear write as well.
		if (irq_clr[IRQ_OVF]) begin
			state_nxt.ovf_pending = 1'b0;
		end
		if (irq_clr[IRQ_FULL]) begin
			state_nxt.full_pending = 1'b0;
		end
		if (irq_clr[IRQ_BUF]) begin
			state_nxt.buf_pending = 1'b0;
		end
		if (rx_overflow_i) begin
			state_nxt.ovf_pending = 1'b1;
		end
		if (fifo_almost_full_i) begin
			state_nxt.full_pending = 1'b1;
		end
		if (buf_take) begin
			state_nxt.buf_pending = 1'b1;
			state_nxt.buf_code = buf_irq_num_i;
		end

		if (rd_go) begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rresp = rd_resp;
			state_nxt.rdata = rd_word;
		end
	end

	// Each field is named so that none is left without a reset value.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r.aw_held <= 1'b0;
			state_r.aw_addr <= '0;
			state_r.w_held <= 1'b0;
			state_r.w_data <= 32'h0000_0000;
			state_r.w_strb <= 4'h0;
			state_r.bvalid <= 1'b0;
			state_r.bresp <= RESP_OKAY;
			state_r.rvalid <= 1'b0;
			state_r.rdata <= 32'h0000_0000;
			state_r.rresp <= RESP_OKAY;
			state_r.matched_filter_index <= '0;
			state_r.buf_pending <= 1'b0;
			state_r.buf_code <= '0;
			state_r.ovf_pending <= 1'b0;
			state_r.full_pending <= 1'b0;
			state_r.dma_buffer_count_sel <= BCS_RESET;
			state_r.fifo_area_first_buffer <= FIRST_RESET;
			state_r.irq_status <= '0;
			state_r.irq_enable <= '0;
			state_r.buf_count <= 6'h04;
		end else begin
			state_r <= state_nxt;
		end
	end
endmodule : can_vector_and_fifo_config

/* File: logic/can_vec_pkg.sv */
// Package with register map, field layout and codes of the vector and FIFO slice.
package can_vec_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_VECTOR = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_BUF_LIMITS = 5'h14;
	localparam int MFI_LSB = 8;
	localparam int MFI_W = 5;
	localparam int CODE_W = 7;
	localparam int BCS_LSB = 13;
	localparam int BCS_W = 3;
	localparam int FIRST_W = 5;
	localparam logic [MFI_W-1:0] FILTER_MAX = 5'h0f;
	localparam logic [CODE_W-1:0] CODE_BUF_MAX = 7'h0f;
	localparam logic [CODE_W-1:0] CODE_RX_OVF = 7'h43;
	localparam logic [CODE_W-1:0] CODE_FIFO_FULL = 7'h44;
	localparam logic [CODE_W-1:0] CODE_NONE = 7'h40;
	localparam logic [BCS_W-1:0] BCS_RESERVED = 3'h7;
	localparam logic [BCS_W-1:0] BCS_RESET = 3'h0;
	localparam logic [FIRST_W-1:0] FIRST_RESET = 5'h00;
	localparam int IRQ_W = 4;
	localparam int IRQ_BUF = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_FULL = 2;
	localparam int IRQ_BADCFG = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : can_vec_pkg

/* File: logic/can_buf_count_dec.sv */
// Decoder from buffer-count selection to number of buffers in DMA RAM.
`timescale 1ns/1ps
module can_buf_count_dec (
	input wire logic [can_vec_pkg::BCS_W-1:0] sel_i,
	output logic [5:0] count_o,
	output logic reserved_o
);
	import can_vec_pkg::*;
	always_comb begin
		reserved_o = 1'b0;
		case (sel_i)
			3'h0: count_o = 6'h04;
			3'h1: count_o = 6'h06;
			3'h2: count_o = 6'h08;
			3'h3: count_o = 6'h0c;
			3'h4: count_o = 6'h10;
			3'h5: count_o = 6'h18;
			3'h6: count_o = 6'h20;
			default: begin
				count_o = 6'h00;
				reserved_o = 1'b1;
			end
		endcase
	end
endmodule : can_buf_count_dec

/* File: logic/can_code_mux.sv */
// Priority selection of the pending interrupt code from event flags.
`timescale 1ns/1ps
module can_code_mux (
	input wire logic ovf_i,
	input wire logic full_i,
	input wire logic buf_valid_i,
	input wire logic [can_vec_pkg::CODE_W-1:0] buf_code_i,
	output logic [can_vec_pkg::CODE_W-1:0] code_o
);
	import can_vec_pkg::*;
	always_comb begin
		// Overflow outranks almost-full since it means data is already lost.
		if (ovf_i) begin
			code_o = CODE_RX_OVF;
		end else if (full_i) begin
			code_o = CODE_FIFO_FULL;
		end else if (buf_valid_i && buf_code_i <= CODE_BUF_MAX) begin
			code_o = buf_code_i;
		end else begin
			code_o = CODE_NONE;
		end
	end
endmodule : can_code_mux

/* File: dv/can_vec_properties.sv */
// Checker of bus handshake, configuration outputs and read data.
`timescale 1ns/1ps
module can_vec_properties (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [can_vec_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [can_vec_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] dma_buffer_count_sel_o,
	input wire logic [5:0] dma_buffer_count_o,
	input wire logic [4:0] fifo_area_first_buffer_o
);
	import can_vec_pkg::*;
	localparam logic [5:0] CNT [8] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10,
		6'h18, 6'h20, 6'h00};
	wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire rd_go = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_count_decode: assert property (
		dma_buffer_count_o == $past(CNT[dma_buffer_count_sel_o]))
		else $error("buffer count does not match selection");
	chk_fifo_write: assert property (
		wr_go && s_axi_awaddr == OFS_FIFO_CTRL && s_axi_wstrb == 4'hf |-> ##2
		fifo_area_first_buffer_o == $past(s_axi_wdata[4:0], 2) &&
		dma_buffer_count_sel_o == $past(s_axi_wdata[15:13], 2))
		else $error("fifo control write not applied");
	chk_cfg_steady: assert property (
		$changed(fifo_area_first_buffer_o) |-> $past(wr_go, 2))
		else $error("fifo start changed without a write");
	chk_vector_bits: assert property (
		rd_go && s_axi_araddr == OFS_VECTOR |=>
		s_axi_rdata[31:13] == 19'h0 && !s_axi_rdata[7])
		else $error("vector read shows bits outside its fields");
	chk_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_write_answer: assert property (
		wr_go |-> ##2 s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (
		rd_go |=> s_axi_rvalid)
		else $error("read response late");
	chk_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_write_refuse: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
endmodule : can_vec_properties

/* File: dv/can_event_model.sv */
// Event source model standing for the protocol engine beside the slice.
`timescale 1ns/1ps
module can_event_model (
	input wire logic clk_i,
	input wire logic [3:0] fire_i,
	input wire logic [6:0] val_i,
	output logic filter_hit_o = 1'b0,
	output logic [4:0] filter_index_o = 5'h00,
	output logic buf_irq_o = 1'b0,
	output logic [6:0] buf_irq_num_o = 7'h00,
	output logic rx_overflow_o = 1'b0,
	output logic fifo_almost_full_o = 1'b0
);
	logic [6:0] junk_r = 7'h2a;
	// Idle value lines move every cycle, so sampling them outside an event shows.
	always_ff @(posedge clk_i) begin
		junk_r <= junk_r + 7'h35;
		filter_hit_o <= fire_i[0];
		filter_index_o <= fire_i[0] ? val_i[4:0] : junk_r[4:0];
		buf_irq_o <= fire_i[1];
		buf_irq_num_o <= fire_i[1] ? val_i : junk_r;
		rx_overflow_o <= fire_i[2];
		fifo_almost_full_o <= fire_i[3];
	end
endmodule : can_event_model

/* File: dv/can_vector_and_fifo_config_test.sv */
// Self-checking bench of the vector and FIFO configuration slice.
`timescale 1ns/1ps
module can_vector_and_fifo_config_test;
	import can_vec_pkg::*;
	localparam logic [5:0] CNT [8] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10,
		6'h18, 6'h20, 6'h00};
	logic clk_i = 1'b0, reset_n_i = 1'b0;
	logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'h0, ev_fire = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq_o, filter_hit_i, buf_irq_i;
	logic rx_overflow_i, fifo_almost_full_i;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [4:0] filter_index_i, fifo_area_first_buffer_o, f;
	logic [6:0] buf_irq_num_i, ev_val = 7'h00, v;
	logic [2:0] dma_buffer_count_sel_o;
	logic [5:0] dma_buffer_count_o;
	int errors = 0, compares = 0;
	can_vector_and_fifo_config u_can_vector_and_fifo_config (.*);
	can_event_model u_can_event_model (.clk_i(clk_i), .fire_i(ev_fire),
		.val_i(ev_val), .filter_hit_o(filter_hit_i),
		.filter_index_o(filter_index_i), .buf_irq_o(buf_irq_i),
		.buf_irq_num_o(buf_irq_num_i), .rx_overflow_o(rx_overflow_i),
		.fifo_almost_full_o(fifo_almost_full_i));
	function automatic logic [31:0] lim(input logic [2:0] s, input logic [4:0] a);
		return {19'h0, a, 2'h0, CNT[s]};
	endfunction : lim
	task automatic check_word(input string n, input logic [31:0] e,
		input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : check_word
	task automatic complete_run;
		if (errors == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		logic aw, w, b;
		b = 1'b1;
		@(posedge clk_i);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (b) begin
			@(negedge clk_i);
			aw = s_axi_awvalid && !s_axi_awready;
			w = s_axi_wvalid && !s_axi_wready;
			b = !s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk_i);
			{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {aw, w, b};
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [4:0] a);
		logic ar, r;
		r = 1'b1;
		@(posedge clk_i);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		while (r) begin
			@(negedge clk_i);
			ar = s_axi_arvalid && !s_axi_arready;
			r = !s_axi_rvalid;
			{rd, resp} = {s_axi_rdata, s_axi_rresp};
			@(posedge clk_i);
			{s_axi_arvalid, s_axi_rready} <= {ar, r};
		end
	endtask : axi_rd
	task automatic fire(input logic [3:0] k, input logic [6:0] x);
		@(posedge clk_i);
		{ev_fire, ev_val} <= {k, x};
		@(posedge clk_i);
		ev_fire <= 4'h0;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask : fire
	task automatic code(input string n, input logic [6:0] e);
		axi_rd(OFS_VECTOR);
		check_word(n, 32'(e), 32'(rd[6:0]));
	endtask : code
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#40000;
		errors++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h9e6e4f54));
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		axi_rd(OFS_VECTOR);
		check_word("vector_reset", 32'h40, rd);
		axi_rd(OFS_BUF_LIMITS);
		check_word("limits_reset", lim(3'h0, 5'h00), rd);
		for (int s = 0; s < 8; s++) begin
			f = (s < 2) ? 5'(31 - s) : 5'($urandom);
			axi_wr(OFS_FIFO_CTRL, {16'($urandom), 3'(s), 8'($urandom), f});
			check_word("ctrl_resp", 32'(RESP_OKAY), 32'(resp));
			axi_rd(OFS_FIFO_CTRL);
			check_word("fifo_ctrl", {16'h0, 3'(s), 8'h0, f}, rd);
			axi_rd(OFS_BUF_LIMITS);
			check_word("limits", lim(3'(s), f), rd);
			check_word("start_out", 32'(f), 32'(fifo_area_first_buffer_o));
		end
		axi_rd(OFS_IRQ_STATUS);
		check_word("status_badcfg", 32'h8, rd);
		axi_wr(OFS_FIFO_CTRL, 32'h0);
		axi_wr(OFS_IRQ_CLEAR, 32'h8);
		for (int i = 0; i < 6; i++) begin
			v = (i < 2) ? 7'(15 * (1 - i)) : 7'($urandom % 16);
			fire(4'h1, v);
			fire(4'h1, v | 7'h10);
			fire(4'h2, v);
			fire(4'h2, v | 7'h10);
			axi_rd(OFS_VECTOR);
			check_word("vector", {19'h0, v[4:0], 1'b0, v}, rd);
			axi_wr(OFS_IRQ_CLEAR, 32'h7);
		end
		code("code_idle", CODE_NONE);
		axi_wr(OFS_IRQ_ENABLE, 32'h2);
		fire(4'h8, 7'h00);
		check_word("irq_masked", 32'h0, 32'(irq_o));
		code("code_full", 7'h44);
		fire(4'h4, 7'h00);
		check_word("irq_on", 32'h1, 32'(irq_o));
		code("code_ovf", 7'h43);
		axi_rd(OFS_IRQ_STATUS);
		check_word("status", 32'h6, rd);
		axi_wr(OFS_IRQ_CLEAR, 32'h2);
		@(negedge clk_i);
		check_word("irq_off", 32'h0, 32'(irq_o));
		code("code_back", 7'h44);
		axi_wr(OFS_VECTOR, 32'hffff);
		axi_rd(OFS_VECTOR);
		check_word("vector_ro", {19'h0, v[4:0], 1'b0, 7'h44}, rd);
		axi_rd(5'h18);
		check_word("unmap_rd", {30'h0, RESP_SLVERR}, {rd[29:0], resp});
		axi_wr(5'h1c, 32'hffff);
		check_word("unmap_wr", 32'(RESP_SLVERR), 32'(resp));
		complete_run();
	end
endmodule : can_vector_and_fifo_config_test
bind can_vector_and_fifo_config can_vec_properties u_can_vec_properties (.*);
